// >>> logic/vrp_pkg.sv
`default_nettype none
package vrp_pkg;
  // clock
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;

  // oscillator select register
  localparam logic [7:0] OSC_REG_ADDR = 8'hf7;
  localparam logic [7:0] OSC_REG_RESET = 8'h00;
  localparam int OSC_USE_REG_BIT = 7;
  localparam int OSC_CODE_W = 5;
  localparam int OSC_STEPS = 32;
  localparam int F_MIN_HZ = 200_000;
  localparam int F_MAX_HZ = 1_000_000;
  localparam int PER_W = 11;

  // phases and rails
  localparam int NPH_MAIN = 4;
  localparam int NPH_ALL = 5;
  localparam int AUX_IDX = 4;
  localparam int NRAIL = 2;

  // timing
  localparam int DETECT_TIME_NS = 30_000;
  localparam int DETECT_CYCLES =
    (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_LATCH_TIME_NS = 50_000;
  localparam int OC_LATCH_CYCLES =
    (OC_LATCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // reference dac and soft start
  localparam int DAC_W = 8;
  localparam int DAC_LSB_UV = 6250;
  localparam int LOW_REF_MV = 250;
  localparam logic [DAC_W-1:0] LOW_REF_CODE =
    DAC_W'(LOW_REF_MV * 1000 / DAC_LSB_UV);
  localparam int SLEW_A_MV_US = 10;
  localparam int SLEW_B_MV_US = 20;
  localparam int SLEW_C_MV_US = 30;
  localparam logic [CNT_W-1:0] SLEW_A_CYC =
    CNT_W'(DAC_LSB_UV * CLK_MHZ / (SLEW_A_MV_US * 1000));
  localparam logic [CNT_W-1:0] SLEW_B_CYC =
    CNT_W'(DAC_LSB_UV * CLK_MHZ / (SLEW_B_MV_US * 1000));
  localparam logic [CNT_W-1:0] SLEW_C_CYC =
    CNT_W'(DAC_LSB_UV * CLK_MHZ / (SLEW_C_MV_US * 1000));

  // current codes
  localparam int CUR_W = 10;

  typedef enum logic [1:0] {
    SHED_NONE = 2'b00,
    SHED_4TO1 = 2'b01,
    SHED_2TO1 = 2'b10
  } vrp_shed_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DETECT = 3'b001,
    ST_SOFT = 3'b010,
    ST_RUN = 3'b011,
    ST_SHUT = 3'b100,
    ST_OVDN = 3'b101
  } vrp_state_t;

  typedef struct packed {
    logic oe;
    logic mid;
    logic high;
  } vrp_drive_t;

  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
  } vrp_fault_t;

  typedef struct packed {
    logic enable;
    logic [3:1] senseHi;
    logic auxSenseHi;
    logic supplyOk;
    logic [NRAIL-1:0][1:0] slewSel;
    logic [OSC_CODE_W-1:0] oscRes;
    logic [NPH_ALL-1:0] pwmReq;
    logic [NPH_MAIN-1:0] phaseOver;
    logic [NRAIL-1:0] uvTrip;
    logic [NRAIL-1:0] ovTrip;
  } vrp_pins_t;
endpackage
`default_nettype wire

// >>> logic/vrp_phase_ramp.sv
`default_nettype none
module vrp_phase_ramp #(
  parameter int CLK_HZ = vrp_pkg::CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [vrp_pkg::OSC_CODE_W-1:0] oscCode,
  input wire logic [1:0] mainLessOne,
  output logic [vrp_pkg::NPH_ALL-1:0] rampSync
);
  import vrp_pkg::*;

  logic [PER_W-1:0] periodTab [OSC_STEPS];
  logic [PER_W-1:0] spaceTab [NPH_MAIN][OSC_STEPS];
  logic [PER_W-1:0] cnt_r;
  logic [PER_W-1:0] period;
  logic [PER_W-1:0] space;
  logic [NPH_ALL-1:0] syncNxt;

  // per-phase period for each of the 32 frequency steps
  for (genvar c = 0; c < OSC_STEPS; c++) begin : g_code
    localparam int FREQ =
      F_MIN_HZ + c * (F_MAX_HZ - F_MIN_HZ) / (OSC_STEPS - 1);
    localparam int PER = CLK_HZ / FREQ;
    assign periodTab[c] = PER_W'(PER);
    for (genvar n = 0; n < NPH_MAIN; n++) begin : g_cnt
      assign spaceTab[n][c] = PER_W'(PER / (n + 1));
    end
  end

  assign period = periodTab[oscCode];
  assign space = spaceTab[mainLessOne][oscCode];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (cnt_r >= period - PER_W'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + PER_W'(1);
    end
  end

  // main ramps equally spaced, aux midway between phases one and two
  for (genvar k = 0; k < NPH_MAIN; k++) begin : g_sync
    assign syncNxt[k] = (2'(k) <= mainLessOne) &&
                        (cnt_r == PER_W'(k) * space);
  end
  assign syncNxt[AUX_IDX] = (cnt_r == (space >> 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rampSync <= '0;
    end else begin
      rampSync <= syncNxt;
    end
  end
endmodule
`default_nettype wire

// >>> logic/vrp_seq_protect.sv
`default_nettype none
module vrp_seq_protect #(
  parameter int DET_CYCLES = vrp_pkg::DETECT_CYCLES,
  parameter int OCL_CYCLES = vrp_pkg::OC_LATCH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire vrp_pkg::vrp_pins_t pinsIn,
  input wire logic [vrp_pkg::NRAIL-1:0][vrp_pkg::DAC_W-1:0] targetCode,
  input wire logic [vrp_pkg::CUR_W-1:0] totalCurrent,
  input wire logic [vrp_pkg::CUR_W-1:0] currentLimit,
  input wire vrp_pkg::vrp_shed_t shedMode,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output vrp_pkg::vrp_drive_t [vrp_pkg::NPH_ALL-1:0] phaseDrive,
  output logic [vrp_pkg::NPH_ALL-1:0] rampSync,
  output logic senseSinkEn,
  output logic compRelease,
  output logic mainGood,
  output logic auxGood,
  output logic [vrp_pkg::NRAIL-1:0][vrp_pkg::DAC_W-1:0] dacCode,
  output vrp_pkg::vrp_fault_t faultStatus
);
  import vrp_pkg::*;

  logic [1:0] rstPipe;
  logic rstn;
  vrp_pins_t pinMeta;
  vrp_pins_t pins;
  logic [1:0] warm_r;
  logic slewTaken_r;
  logic [NRAIL-1:0][1:0] slew_r;
  logic [7:0] oscReg_r;
  logic [OSC_CODE_W-1:0] oscCode;
  vrp_state_t stateR, stateNxt;
  logic [CNT_W-1:0] detCnt_r, ocCnt_r;
  logic detDone, run, en;
  logic [NPH_ALL-1:0] strapR, phaseActive, firedR;
  logic [1:0] mainLessOne;
  logic [CUR_W-1:0] limitScaled;
  logic [CUR_W+1:0] tot2, lim3;
  logic over100, over150, phaseTrip, ocExpire;
  logic ocFault, uvFault, ovFault;
  logic [NRAIL-1:0] railOn, rampDone;
  vrp_fault_t faultR;
  vrp_drive_t [NPH_ALL-1:0] driveNxt, driveR;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstn = rstPipe[1];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= '0;
      pins <= '0;
    end else begin
      pinMeta <= pinsIn;
      pins <= pinMeta;
    end
  end

  // slew straps caught once the synchroniser holds real pin levels
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      warm_r <= 2'b00;
      slewTaken_r <= 1'b0;
      slew_r <= '0;
    end else begin
      warm_r <= {warm_r[0], 1'b1};
      if (warm_r[1] && !slewTaken_r) begin
        slewTaken_r <= 1'b1;
        slew_r <= pins.slewSel;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oscReg_r <= OSC_REG_RESET;
    end else if (regWrEn && regAddr == OSC_REG_ADDR) begin
      oscReg_r <= regWrData;
    end
  end
  assign oscCode = oscReg_r[OSC_USE_REG_BIT] ?
                   oscReg_r[OSC_CODE_W-1:0] : pins.oscRes;

  // read back shows the code actually in use
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (regAddr == OSC_REG_ADDR) begin
      regRdData <= {oscReg_r[OSC_USE_REG_BIT],
                    {(7 - OSC_CODE_W){1'b0}}, oscCode};
    end else begin
      regRdData <= 8'h00;
    end
  end

  vrp_phase_ramp #(.CLK_HZ(CLK_HZ)) u_ramp (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .oscCode(oscCode),
    .mainLessOne(mainLessOne),
    .rampSync(rampSync)
  );

  assign en = pins.enable;
  assign run = (stateR == ST_SOFT) || (stateR == ST_RUN);
  assign detDone = (detCnt_r == CNT_W'(DET_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      detCnt_r <= '0;
    end else if (stateR == ST_DETECT) begin
      detCnt_r <= detCnt_r + CNT_W'(1);
    end else begin
      detCnt_r <= '0;
    end
  end

  // strap configuration frozen at end of detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strapR <= '0;
    end else if (!en) begin
      strapR <= '0;
    end else if (stateR == ST_DETECT && detDone) begin
      strapR <= {pins.auxSenseHi, pins.senseHi, 1'b0};
    end
  end

  always_comb begin
    if (strapR[3:1] == 3'b111) begin
      mainLessOne = 2'd0;
    end else if (strapR[3:1] == 3'b101) begin
      mainLessOne = 2'd1;
    end else if (strapR[3]) begin
      mainLessOne = 2'd2;
    end else begin
      mainLessOne = 2'd3;
    end
  end

  for (genvar k = 0; k < NPH_MAIN; k++) begin : g_act
    // the strap alone decides: two-phase mode keeps phases one and three
    assign phaseActive[k] = !strapR[k];
  end
  assign phaseActive[AUX_IDX] = !strapR[AUX_IDX];
  assign railOn = {!strapR[AUX_IDX], 1'b1};

  always_comb begin
    unique case (shedMode)
      SHED_4TO1: limitScaled = currentLimit >> 2;
      SHED_2TO1: limitScaled = currentLimit >> 1;
      default: limitScaled = currentLimit;
    endcase
  end
  assign tot2 = {1'b0, totalCurrent, 1'b0};
  assign lim3 = {1'b0, limitScaled, 1'b0} + {2'b00, limitScaled};
  assign over100 = totalCurrent > limitScaled;
  assign over150 = tot2 > lim3;
  assign phaseTrip = (|(pins.phaseOver & phaseActive[NPH_MAIN-1:0])) &&
                     (dacCode[0] < LOW_REF_CODE);
  assign ocExpire = (ocCnt_r == CNT_W'(OCL_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ocCnt_r <= '0;
    end else if (run && over100 && !ocExpire) begin
      ocCnt_r <= ocCnt_r + CNT_W'(1);
    end else if (!(run && over100)) begin
      ocCnt_r <= '0;
    end
  end

  assign ocFault = run && (over150 || phaseTrip ||
                           (over100 && ocExpire));
  assign uvFault = (stateR == ST_RUN) && |(pins.uvTrip & railOn);
  assign ovFault = run && |(pins.ovTrip & railOn);

  always_comb begin
    stateNxt = stateR;
    if (!en) begin
      stateNxt = ST_IDLE;
    end else begin
      unique case (stateR)
        ST_IDLE: if (pins.supplyOk) stateNxt = ST_DETECT;
        ST_DETECT: begin
          if (!pins.supplyOk) stateNxt = ST_IDLE;
          else if (detDone) stateNxt = ST_SOFT;
        end
        ST_SOFT: begin
          if (!pins.supplyOk) stateNxt = ST_IDLE;
          else if (ovFault) stateNxt = ST_OVDN;
          else if (ocFault) stateNxt = ST_SHUT;
          else if (&rampDone) stateNxt = ST_RUN;
        end
        ST_RUN: begin
          if (!pins.supplyOk) stateNxt = ST_IDLE;
          else if (ovFault) stateNxt = ST_OVDN;
          else if (ocFault || uvFault) stateNxt = ST_SHUT;
        end
        ST_SHUT: stateNxt = ST_SHUT;
        ST_OVDN: stateNxt = ST_OVDN;
        default: stateNxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stateR <= ST_IDLE;
    end else begin
      stateR <= stateNxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      faultR <= '0;
    end else if (!en) begin
      faultR <= '0;
    end else begin
      faultR.ov <= faultR.ov | ovFault;
      faultR.uv <= faultR.uv | uvFault;
      faultR.oc <= faultR.oc | ocFault;
    end
  end
  assign faultStatus = faultR;

  // per-rail soft start counter
  for (genvar r = 0; r < NRAIL; r++) begin : g_rail
    logic [CNT_W-1:0] stepCnt_r;
    logic [CNT_W-1:0] stepLen;
    logic tick;
    logic railOff;
    assign stepLen = (slew_r[r] == 2'd0) ? SLEW_A_CYC :
                     (slew_r[r] == 2'd1) ? SLEW_B_CYC : SLEW_C_CYC;
    assign tick = (stepCnt_r >= stepLen - CNT_W'(1));
    assign railOff = !railOn[r];
    assign rampDone[r] = railOff || (dacCode[r] == targetCode[r]);
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        stepCnt_r <= '0;
        dacCode[r] <= '0;
      end else if (!(run || stateR == ST_OVDN) || railOff) begin
        stepCnt_r <= '0;
        dacCode[r] <= '0;
      end else begin
        stepCnt_r <= tick ? '0 : stepCnt_r + CNT_W'(1);
        if (tick) begin
          if (stateR == ST_OVDN) begin
            if (dacCode[r] != '0) dacCode[r] <= dacCode[r] - DAC_W'(1);
          end else if (dacCode[r] < targetCode[r]) begin
            dacCode[r] <= dacCode[r] + DAC_W'(1);
          end else if (dacCode[r] > targetCode[r]) begin
            dacCode[r] <= dacCode[r] - DAC_W'(1);
          end
        end
      end
    end
  end

  // tri-level drive per phase
  for (genvar k = 0; k < NPH_ALL; k++) begin : g_drv
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        firedR[k] <= 1'b0;
      end else if (!run) begin
        firedR[k] <= 1'b0;
      end else if (pins.pwmReq[k]) begin
        firedR[k] <= 1'b1;
      end
    end
    always_comb begin
      driveNxt[k] = '{oe: 1'b1, mid: 1'b0, high: 1'b0};
      if (stateR == ST_DETECT) begin
        driveNxt[k].mid = (k != 0);
      end else if (stateR != ST_IDLE && !phaseActive[k]) begin
        driveNxt[k].oe = 1'b0;
      end else if (run) begin
        if (!firedR[k] && !pins.pwmReq[k]) begin
          driveNxt[k].mid = 1'b1;
        end else begin
          driveNxt[k].high = pins.pwmReq[k];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      driveR <= '0;
      mainGood <= 1'b0;
      auxGood <= 1'b0;
    end else begin
      driveR <= driveNxt;
      mainGood <= (stateNxt == ST_RUN);
      auxGood <= (stateNxt == ST_RUN) && railOn[1];
    end
  end
  assign phaseDrive = driveR;
  assign senseSinkEn = (stateR == ST_DETECT);
  assign compRelease = run;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_detect_len: assert property (
    stateR == ST_SOFT && $past(stateR) == ST_DETECT |->
      $past(detCnt_r) == CNT_W'(DET_CYCLES - 1))
    else $error("detection interval length wrong");
  a_phase1_low: assert property (
    $past(stateR) == ST_DETECT |-> !driveR[0].high && !driveR[0].mid)
    else $error("phase one not low in detection");
  a_sink_window: assert property (
    senseSinkEn |-> en && $past(stateR) inside {ST_IDLE, ST_DETECT})
    else $error("sense sinks active outside detection");
  a_one_phase: assert property (
    run && strapR[3:1] == 3'b111 |-> mainLessOne == 2'd0)
    else $error("one-phase strap not decoded");
  a_strap_hiz: assert property (
    run && strapR[3] |=> !driveR[3].oe)
    else $error("strapped phase still driven");
  a_aux_off: assert property (
    stateR == ST_RUN && strapR[AUX_IDX] |=> !auxGood && !driveR[4].oe)
    else $error("aux rail active while strapped off");
  a_mid_start: assert property (
    $past(stateR) == ST_IDLE && stateR == ST_DETECT |=>
      driveR[1].mid && !compRelease)
    else $error("phases not mid at enable");
  a_mid_hold: assert property (
    stateR == ST_SOFT && stateNxt == ST_SOFT && phaseActive[1] &&
    !firedR[1] && !pins.pwmReq[1] |=> driveR[1].mid)
    else $error("phase left mid before first pulse");
  a_oc_fast: assert property (
    run && over150 && !ovFault && pins.supplyOk && en |=>
      stateR == ST_SHUT)
    else $error("150 percent overcurrent not immediate");
  a_oc_timer: assert property (
    run && over100 && !over150 && !phaseTrip |->
      stateNxt != ST_SHUT || ocExpire || uvFault)
    else $error("overcurrent shutdown before timer");
  a_oc_latched: assert property (
    stateR == ST_SHUT && en |=> stateR == ST_SHUT && faultR != '0)
    else $error("shutdown not latched");
  a_uv_good: assert property (
    stateR == ST_RUN && uvFault |=> !mainGood ##1 !mainGood)
    else $error("power good stays high on undervoltage");
  a_ov_ramp: assert property (
    stateR == ST_OVDN && $past(stateR) == ST_OVDN |->
      dacCode[0] <= $past(dacCode[0]) && !driveR[0].high)
    else $error("overvoltage shutdown not ramping down");
  a_supply_lockout_gate: assert property (
    stateR != ST_IDLE && !pins.supplyOk && en &&
    stateR inside {ST_DETECT, ST_SOFT, ST_RUN} |=> stateR == ST_IDLE)
    else $error("supply lockout ignored");

  c_reach_run: cover property (stateR == ST_SOFT ##1 stateR == ST_RUN);
  c_oc_shut: cover property (run && ocFault ##1 stateR == ST_SHUT);
  c_ov_down: cover property (stateR == ST_RUN ##1 stateR == ST_OVDN);
  c_one_phase: cover property (stateR == ST_RUN && mainLessOne == 2'd0);
endmodule
`default_nettype wire

// >>> verif/vrp_stage_model.sv
`default_nettype none
module vrp_stage_model (
  input wire logic clk_sys,
  input wire vrp_pkg::vrp_drive_t [vrp_pkg::NPH_ALL-1:0] phaseDrive,
  input wire logic [vrp_pkg::CUR_W-1:0] loadCur,
  output logic [vrp_pkg::CUR_W-1:0] totalCurrent
);
  import vrp_pkg::*;
  logic anyOn;
  always_comb begin
    anyOn = 1'b0;
    for (int k = 0; k < NPH_ALL; k++)
      anyOn = anyOn | (phaseDrive[k].oe & ~phaseDrive[k].mid);
  end
  // inductor current flows whenever some phase is driven high or low, not only mid or hi-z
  always_ff @(posedge clk_sys)
    totalCurrent <= anyOn ? loadCur : '0;
endmodule
`default_nettype wire

// >>> verif/vrp_seq_protect_tb_top.sv
`default_nettype none
module vrp_seq_protect_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vrp_pkg::*;
  localparam int DET = 20;
  localparam int OCL = 16;
  logic clk_sys, resetn, regWrEn, sinkEn, compRel, mainGood, auxGood;
  vrp_pins_t pins;
  logic [NRAIL-1:0][DAC_W-1:0] target, dac;
  logic [CUR_W-1:0] loadCur, limit, totCur;
  vrp_shed_t shed;
  logic [7:0] regAddr, regWrData, regRdData, rd;
  vrp_drive_t [NPH_ALL-1:0] drv;
  logic [NPH_ALL-1:0] ramp;
  vrp_fault_t flt;
  int n_errors = 0;
  int checks_done = 0;

  vrp_seq_protect #(.DET_CYCLES(DET), .OCL_CYCLES(OCL)) vrp_seq_protect_i (
    .clk_sys(clk_sys), .resetn(resetn), .pinsIn(pins),
    .targetCode(target), .totalCurrent(totCur), .currentLimit(limit),
    .shedMode(shed), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .phaseDrive(drv),
    .rampSync(ramp), .senseSinkEn(sinkEn), .compRelease(compRel),
    .mainGood(mainGood), .auxGood(auxGood), .dacCode(dac),
    .faultStatus(flt));
  vrp_stage_model vrp_stage_model_i (.clk_sys(clk_sys), .phaseDrive(drv),
    .loadCur(loadCur), .totalCurrent(totCur));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  function automatic logic cond(input int w);
    case (w)
      0: return sinkEn;
      1: return compRel;
      2: return mainGood;
      3: return flt.oc;
      4: return flt.uv;
      5: return flt.ov;
      default: return dac[0] == 8'h00;
    endcase
  endfunction

  task automatic waitFor(input int w, input int maxc);
    int k;
    k = 0;
    while (cond(w) !== 1'b1 && k < maxc) begin
      cyc(1);
      k++;
    end
    if (cond(w) !== 1'b1) begin
      n_errors++;
      $display("[ERR] wait %0d expected 1 seen timeout", w);
      summarize();
    end
  endtask

  function automatic logic [4:0] oeVec();
    for (int k = 0; k < NPH_ALL; k++)
      oeVec[k] = drv[k].oe;
  endfunction

  task automatic regWr(input logic [7:0] a, d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    cyc(1);
    regWrEn = 1'b0;
  endtask

  task automatic regRd(input logic [7:0] a);
    regAddr = a;
    cyc(2);
    rd = regRdData;
  endtask

  task automatic startup(input logic [3:1] straps, input logic aux);
    pins.enable = 1'b0;
    cyc(4);
    pins.senseHi = straps;
    pins.auxSenseHi = aux;
    pins.enable = 1'b1;
    waitFor(1, DET + 10);
    waitFor(2, 600);
    pins.pwmReq[0] = 1'b1;
    cyc(1);
    pins.pwmReq[0] = 1'b0;
    cyc(3);
  endtask

  task automatic t_reg();
    regRd(8'hf7);
    chk("osc reset", 16'h04, rd);
    regWr(8'hf7, 8'h85);
    regRd(8'hf7);
    chk("osc reg", 16'h85, rd);
    regWr(8'hf7, 8'h7f);
    regRd(8'hf7);
    chk("osc res sel", 16'h04, rd);
    regWr(8'hf6, 8'haa);
    regRd(8'hf7);
    chk("osc kept", 16'h04, rd);
    regRd(8'hf6);
    chk("unmapped", 16'h00, rd);
    $display("test reg done");
  endtask

  task automatic t_detect();
    logic [7:0] prev;
    int k;
    logic bad;
    pins.supplyOk = 1'b0;
    pins.senseHi = 3'b101;
    pins.auxSenseHi = 1'b1;
    pins.enable = 1'b1;
    cyc(8);
    chk("lockout", 0, sinkEn);
    pins.enable = 1'b0;
    cyc(4);
    pins.supplyOk = 1'b1;
    pins.enable = 1'b1;
    waitFor(0, 8);
    cyc(2);
    chk("ph1 low", 3'b100, drv[0]);
    chk("ph3 mid", 1, drv[2].mid);
    chk("comp held", 0, compRel);
    cyc(DET - 6);
    chk("ph1 still low", 3'b100, drv[0]);
    waitFor(1, 10);
    cyc(2);
    chk("sink off", 0, sinkEn);
    chk("hi z", 5'b00101, oeVec());
    chk("dac start", 0, dac[0]);
    pins.senseHi = 3'b000;
    pins.auxSenseHi = 1'b0;
    prev = dac[0];
    k = 0;
    bad = 1'b0;
    while (mainGood !== 1'b1 && k < 600) begin
      cyc(1);
      k++;
      if (dac[0] != prev && dac[0] != prev + 8'h01)
        bad = 1'b1;
      prev = dac[0];
    end
    chk("dac steps", 0, bad);
    chk("ramp time", 1, k >= (6 - 1) * SLEW_C_CYC);
    chk("dac final", target[0], dac[0]);
    chk("config held", 5'b00101, oeVec());
    pins.pwmReq[0] = 1'b1;
    cyc(4);
    chk("ph1 pulse", 3'b101, drv[0]);
    chk("ph3 still mid", 1, drv[2].mid);
    pins.pwmReq[2] = 1'b1;
    cyc(4);
    chk("overlap", 2'b11, {drv[0].high, drv[2].high});
    pins.pwmReq = '0;
    $display("test detect done");
  endtask

  task automatic t_oc();
    startup(3'b000, 1'b0);
    loadCur = 10'd200;
    waitFor(3, 6);
    loadCur = 10'd0;
    cyc(5);
    chk("oc latched", 1, flt.oc);
    pins.enable = 1'b0;
    cyc(4);
    chk("oc cleared", 0, flt.oc);
    startup(3'b000, 1'b0);
    loadCur = 10'd120;
    cyc(8);
    loadCur = 10'd0;
    cyc(4);
    chk("oc burst", 0, flt.oc);
    loadCur = 10'd120;
    cyc(OCL - 6);
    chk("oc early", 0, flt.oc);
    waitFor(3, 12);
    loadCur = 10'd0;
    $display("test oc done");
  endtask

  task automatic t_shed();
    vrp_shed_t modes[2] = '{SHED_4TO1, SHED_2TO1};
    logic [CUR_W-1:0] loads[2] = '{10'd30, 10'd60};
    for (int i = 0; i < 2; i++) begin
      startup(3'b000, 1'b0);
      shed = modes[i];
      loadCur = loads[i];
      cyc(OCL - 6);
      chk("shed early", 0, flt.oc);
      waitFor(3, 12);
      loadCur = 10'd0;
      shed = SHED_NONE;
    end
    $display("test shed done");
  endtask

  task automatic t_uvov();
    startup(3'b000, 1'b0);
    chk("both good", 2'b11, {mainGood, auxGood});
    pins.uvTrip[0] = 1'b1;
    cyc(4);
    chk("good low", 0, mainGood);
    pins.uvTrip[0] = 1'b0;
    cyc(4);
    chk("uv held", 2'b10, {flt.uv, mainGood});
    pins.enable = 1'b0;
    cyc(4);
    chk("uv cleared", 0, flt.uv);
    startup(3'b000, 1'b0);
    pins.ovTrip[0] = 1'b1;
    waitFor(5, 6);
    cyc(2);
    chk("ov drive low", 3'b100, drv[0]);
    waitFor(6, 400);
    pins.ovTrip[0] = 1'b0;
    cyc(4);
    chk("ov held", 1, flt.ov);
    pins.enable = 1'b0;
    $display("test uvov done");
  endtask

  initial begin
    resetn = 1'b0;
    pins = '0;
    pins.slewSel = 4'ha;
    pins.oscRes = 5'h04;
    target = {8'h06, 8'h06};
    loadCur = '0;
    limit = 10'd100;
    shed = SHED_NONE;
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    cyc(6);
    t_reg();
    t_detect();
    t_oc();
    t_shed();
    t_uvov();
    summarize();
  end
endmodule
`default_nettype wire
